// ==== rtl/rmsp_port.sv ====
// How it works
// - RMII timed only by external 50 MHz reference
// - RMII runs at 10 and 100 Mbps
// - Independent 2-bit transmit and receive paths
// - Frames go to and from third MAC
// - No receive-error output; errors flagged inward
// - Transmit-error input marks incoming frame errored in RMII mode only
// - RMII collision: carrier while transmitting, half duplex
// - Works with RMII PHY or MAC partner
// - MAC-to-MAC: valid feeds enable, data crosses
// - Serial mode: device is the PHY end
// - Serial mode: one bit per clock, uncoded
// - Receive-valid output is serial carrier sense
// - Serial half duplex drives collision output
`timescale 1ns/1ps
`default_nettype none
module rmsp_port (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire rmsp_pkg::rmsp_mode_t mode,
    input  wire logic                speed_100,
    input  wire logic                full_duplex,
    input  wire logic                ref_clock_in,
    input  wire logic                tx_enable_in,
    input  wire logic [3:0]          tx_data_in,
    input  wire logic                tx_error_in,
    output var  logic                rx_valid_out,
    output var  logic [1:0]          rx_data_out,
    output var  logic                collision_out,
    output var  logic                tx_clock_pin,
    output var  logic                rx_clock_pin,
    output var  rmsp_pkg::rmsp_rxb_t mac_rx,
    input  wire logic                mac_tx_valid,
    input  wire logic [7:0]          mac_tx_data,
    input  wire logic                mac_tx_last,
    output var  logic                mac_tx_ready,
    output var  logic                mac_collision
);
    logic       ref_s, en_s, er_s;
    logic [1:0] txd_s;
    logic       is_sni;
    logic       ref_d, next_ref_d;
    logic [3:0] slow, next_slow;
    logic [1:0] ph, next_ph;
    logic       ref_rise, rmii_stb, sni_smp, sni_drv;
    logic       rx_stb, drv_stb;

    // Upper data bits are unused here and expected tied low
    rmsp_sync #(.W(rmsp_pkg::RMSP_SYNC_W)) u_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .d    ({ref_clock_in, tx_enable_in, tx_error_in, tx_data_in[1:0]}),
        .q    ({ref_s, en_s, er_s, txd_s})
    );

    assign is_sni = (mode == rmsp_pkg::RMSP_SNI);

    // Reference edge detect and 10 Mbps symbol pacing
    always_comb begin
        next_ref_d = ref_s;
        next_slow  = slow;
        next_ph    = (ph == rmsp_pkg::RMSP_SNI_LAST) ? 2'h0 : ph + 2'h1;
        if (ref_rise) begin
            next_slow = (slow == rmsp_pkg::RMSP_SLOW_LAST) ? 4'h0 : slow + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ref_d <= 1'b0;
            slow  <= 4'h0;
            ph    <= 2'h0;
        end else if (ce) begin
            ref_d <= next_ref_d;
            slow  <= next_slow;
            ph    <= next_ph;
        end
    end

    // Both paths use only the partner-supplied reference in RMII
    assign ref_rise = ref_s & ~ref_d;
    // A PHY or MAC partner looks the same on these pins
    assign rmii_stb = ref_rise & (speed_100 | (slow == 4'h0));
    assign sni_smp  = (ph == rmsp_pkg::RMSP_SNI_SAMPLE);
    assign sni_drv  = (ph == rmsp_pkg::RMSP_SNI_DRIVE);
    assign rx_stb   = is_sni ? sni_smp : rmii_stb;
    assign drv_stb  = is_sni ? sni_drv : rmii_stb;

    // Incoming enable is the partner's carrier/valid; its data crosses to ours
    rmsp_deser u_deser (
        .clk     (clk),
        .srst    (srst),
        .ce      (ce),
        .strobe  (rx_stb),
        .active  (en_s),
        .one_bit (is_sni),
        .sym     (txd_s),
        .err     (er_s & ~is_sni),
        .out     (mac_rx)
    );

    // Outgoing path: one holding byte ahead of the shifter
    logic [7:0] hold, next_hold;
    logic       hold_full, next_hold_full;
    logic       hold_last, next_hold_last;
    logic [7:0] sh, next_sh;
    logic [3:0] left, next_left;
    logic       sh_last, next_sh_last;
    logic       next_valid;
    logic [1:0] next_rxd;
    logic       next_ready;
    logic       col, next_col, next_mcol;
    logic       next_txc, next_rxc;
    logic       accept;

    assign accept = mac_tx_valid & mac_tx_ready;

    always_comb begin
        logic [7:0] cur;
        logic [3:0] rem;
        logic       lst;
        logic [3:0] step;
        cur            = sh;
        rem            = left;
        lst            = sh_last;
        step           = is_sni ? rmsp_pkg::RMSP_STEP_BIT : rmsp_pkg::RMSP_STEP_DIBIT;
        next_hold      = hold;
        next_hold_full = hold_full;
        next_hold_last = hold_last;
        next_sh        = sh;
        next_left      = left;
        next_sh_last   = sh_last;
        next_valid     = rx_valid_out;
        next_rxd       = rx_data_out;
        if (accept) begin
            next_hold      = mac_tx_data;
            next_hold_full = 1'b1;
            next_hold_last = mac_tx_last;
        end
        if (drv_stb) begin
            // One idle symbol after a last byte keeps frames apart
            if (rem == 4'h0 && hold_full && !(sh_last && rx_valid_out)) begin
                cur            = hold;
                rem            = rmsp_pkg::RMSP_BYTE_BITS;
                lst            = hold_last;
                next_hold_full = 1'b0;
            end
            if (rem != 4'h0) begin
                next_rxd     = is_sni ? {1'b0, cur[0]} : cur[1:0];
                next_valid   = 1'b1;
                next_sh      = is_sni ? {1'b0, cur[7:1]} : {2'h0, cur[7:2]};
                next_left    = rem - step;
                next_sh_last = lst;
            end else begin
                next_rxd     = 2'h0;
                next_valid   = 1'b0;
                next_sh_last = 1'b0;
            end
        end
        next_ready = ~next_hold_full;
    end

    // Collision is partner carrier seen while we transmit, half duplex only
    always_comb begin
        col       = ~full_duplex & rx_valid_out & en_s;
        next_mcol = col;
        next_col  = col & is_sni;
        // The device makes the serial clocks; nothing is driven in RMII
        next_txc  = is_sni & (next_ph < rmsp_pkg::RMSP_SNI_HIGH);
        next_rxc  = next_txc;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hold          <= '0;
            hold_full     <= 1'b0;
            hold_last     <= 1'b0;
            sh            <= '0;
            left          <= 4'h0;
            sh_last       <= 1'b0;
            rx_valid_out  <= 1'b0;
            rx_data_out   <= 2'h0;
            mac_tx_ready  <= 1'b0;
            collision_out <= 1'b0;
            mac_collision <= 1'b0;
            tx_clock_pin  <= 1'b0;
            rx_clock_pin  <= 1'b0;
        end else if (ce) begin
            hold          <= next_hold;
            hold_full     <= next_hold_full;
            hold_last     <= next_hold_last;
            sh            <= next_sh;
            left          <= next_left;
            sh_last       <= next_sh_last;
            rx_valid_out  <= next_valid;
            rx_data_out   <= next_rxd;
            mac_tx_ready  <= next_ready;
            collision_out <= next_col;
            mac_collision <= next_mcol;
            tx_clock_pin  <= next_txc;
            rx_clock_pin  <= next_rxc;
        end
    end

    a_ref_only: assert property (@(posedge clk) disable iff (srst || !ce)
        !is_sni |=> !tx_clock_pin && !rx_clock_pin)
        else $error("clock driven in RMII mode");
    a_slow_pace: assert property (@(posedge clk) disable iff (srst || !ce)
        !is_sni && !speed_100 && rmii_stb |=> !rmii_stb [*8])
        else $error("10 Mbps symbols too close");
    a_dibit_out: assert property (@(posedge clk) disable iff (srst || !ce)
        !is_sni && drv_stb && left != 4'h0
        |=> rx_valid_out && rx_data_out == $past(sh[1:0]))
        else $error("di-bit not driven from shifter");
    a_ready_hold: assert property (@(posedge clk) disable iff (srst || !ce)
        accept |=> !mac_tx_ready && hold == $past(mac_tx_data))
        else $error("accepted byte not held");
    a_rmii_col: assert property (@(posedge clk) disable iff (srst || !ce)
        !full_duplex && rx_valid_out && en_s |=> mac_collision)
        else $error("collision not flagged");
    a_fd_nocol: assert property (@(posedge clk) disable iff (srst || !ce)
        full_duplex |=> !mac_collision && !collision_out)
        else $error("collision in full duplex");
    a_sni_bit: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni && sni_drv && left != 4'h0
        |=> rx_valid_out && rx_data_out == {1'b0, $past(sh[0])})
        else $error("serial bit not driven");
    a_crs_idle: assert property (@(posedge clk) disable iff (srst || !ce)
        !rx_valid_out |-> rx_data_out == 2'h0)
        else $error("data without carrier sense");
    a_sni_col: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni && !full_duplex && rx_valid_out && en_s |=> collision_out)
        else $error("serial collision missed");
    a_sni_clk: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni && $rose(tx_clock_pin) && $past(is_sni)
        |=> tx_clock_pin ##1 !tx_clock_pin ##1 !tx_clock_pin)
        else $error("serial clock shape wrong");

    // The partner samples anywhere in a symbol, so nothing moves between strobes
    a_out_steady: assert property (@(posedge clk) disable iff (srst || !ce)
        !drv_stb
        |=> $stable(rx_data_out) && $stable(rx_valid_out))
        else $error("link outputs moved between strobes");

    a_dibit_steps: assert property (@(posedge clk) disable iff (srst || !ce)
        !is_sni && drv_stb && left != 4'h0
        |=> left == $past(left) - rmsp_pkg::RMSP_STEP_DIBIT)
        else $error("di-bit count not stepped by two");

    a_frame_gap: assert property (@(posedge clk) disable iff (srst || !ce)
        drv_stb && left == 4'h0 && sh_last && rx_valid_out
        |=> !rx_valid_out)
        else $error("no idle symbol after last byte");

    a_underrun_end: assert property (@(posedge clk) disable iff (srst || !ce)
        drv_stb && left == 4'h0 && !hold_full
        |=> !rx_valid_out)
        else $error("frame kept going with nothing held");

    a_load_ready: assert property (@(posedge clk) disable iff (srst || !ce)
        drv_stb && left == 4'h0 && hold_full && !(sh_last && rx_valid_out)
        |=> mac_tx_ready && rx_valid_out)
        else $error("held byte not loaded at strobe");

    a_ready_mirror: assert property (@(posedge clk) disable iff (srst || !ce)
        mac_tx_ready
        |-> !hold_full)
        else $error("ready while a byte is held");

    a_col_needs_tx: assert property (@(posedge clk) disable iff (srst || !ce)
        mac_collision
        |-> $past(rx_valid_out) && !$past(full_duplex))
        else $error("collision without own transmission");

    a_rmii_nopin: assert property (@(posedge clk) disable iff (srst || !ce)
        !is_sni
        |=> !collision_out)
        else $error("collision pin driven in RMII mode");

    a_serial_top: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni && rx_valid_out
        |-> rx_data_out[1] == 1'b0)
        else $error("serial data on upper bit");

    a_clk_pair: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni
        |-> rx_clock_pin == tx_clock_pin)
        else $error("serial clocks differ");

    a_sni_pace: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni && sni_drv
        |=> !sni_drv [*3] ##1 sni_drv)
        else $error("serial drive strobe not every fourth clock");

    a_bit_steps: assert property (@(posedge clk) disable iff (srst || !ce)
        is_sni && sni_drv && left != 4'h0
        |=> left == $past(left) - rmsp_pkg::RMSP_STEP_BIT)
        else $error("serial bit count not stepped by one");
endmodule
`default_nettype wire

// ==== common/rmsp_pkg.sv ====
`default_nettype none
package rmsp_pkg;
    // Port personality: reduced-pin di-bit link or 7-wire serial PHY end
    typedef enum logic {RMSP_RMII, RMSP_SNI} rmsp_mode_t;

    // Byte stream handed to the third MAC's receive queue
    typedef struct packed {
        logic       sof;
        logic       eof;
        logic       err;
        logic       valid;
        logic [7:0] data;
    } rmsp_rxb_t;

    localparam int         RMSP_CLK_HZ     = 40_000_000;
    localparam int         RMSP_REF_HZ     = 50_000_000;
    localparam int         RMSP_SNI_BIT_HZ = 10_000_000;
    localparam int         RMSP_SNI_DIV    = RMSP_CLK_HZ / RMSP_SNI_BIT_HZ;
    localparam logic [1:0] RMSP_SNI_LAST   = 2'(RMSP_SNI_DIV - 1);
    localparam logic [1:0] RMSP_SNI_HIGH   = 2'(RMSP_SNI_DIV / 2);
    localparam logic [1:0] RMSP_SNI_SAMPLE = 2'h1;
    localparam logic [1:0] RMSP_SNI_DRIVE  = 2'h2;
    localparam logic [3:0] RMSP_SLOW_LAST  = 4'h9;
    localparam logic [3:0] RMSP_STEP_BIT   = 4'h1;
    localparam logic [3:0] RMSP_STEP_DIBIT = 4'h2;
    localparam logic [3:0] RMSP_BYTE_BITS  = 4'h8;
    localparam int         RMSP_SYNC_W     = 5;
endpackage
`default_nettype wire

// ==== rtl/rmsp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmsp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/rmsp_deser.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmsp_deser (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              strobe,
    input  wire logic              active,
    input  wire logic              one_bit,
    input  wire logic [1:0]        sym,
    input  wire logic              err,
    output var  rmsp_pkg::rmsp_rxb_t out
);
    logic [7:0] acc, next_acc;
    logic [3:0] cnt, next_cnt;
    logic       fr, next_fr;
    logic       first, next_first;
    logic       err_seen, next_err;
    rmsp_pkg::rmsp_rxb_t next_out;

    always_comb begin
        logic [3:0] base;
        base       = fr ? cnt : 4'h0;
        next_acc   = acc;
        next_cnt   = cnt;
        next_fr    = fr;
        next_first = first;
        next_err   = err_seen;
        next_out   = '0;
        if (strobe && active) begin
            next_acc = one_bit ? {sym[0], acc[7:1]} : {sym, acc[7:2]};
            next_cnt = base + (one_bit ? rmsp_pkg::RMSP_STEP_BIT : rmsp_pkg::RMSP_STEP_DIBIT);
            next_err = (fr & err_seen) | err;
            if (!fr) begin
                next_fr    = 1'b1;
                next_first = 1'b1;
            end
            if (next_cnt == rmsp_pkg::RMSP_BYTE_BITS) begin
                next_out.valid = 1'b1;
                next_out.data  = next_acc;
                next_out.sof   = next_first;
                next_first     = 1'b0;
                next_cnt       = 4'h0;
            end
        end else if (strobe && fr) begin
            // A trailing partial byte is dropped; the error is only reported inward
            next_out.eof = 1'b1;
            next_out.err = err_seen;
            next_fr      = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc      <= '0;
            cnt      <= '0;
            fr       <= 1'b0;
            first    <= 1'b0;
            err_seen <= 1'b0;
            out      <= '0;
        end else if (ce) begin
            acc      <= next_acc;
            cnt      <= next_cnt;
            fr       <= next_fr;
            first    <= next_first;
            err_seen <= next_err;
            out      <= next_out;
        end
    end

    a_dibit_byte: assert property (@(posedge clk) disable iff (srst || !ce)
        strobe && active && fr && !one_bit && cnt == 4'h6
        |=> out.valid && out.data[7:6] == $past(sym))
        else $error("di-bit not placed in byte top");
    a_err_mark: assert property (@(posedge clk) disable iff (srst || !ce)
        strobe && !active && fr && err_seen |=> out.eof && out.err)
        else $error("errored frame not marked at end");
endmodule
`default_nettype wire

// ==== tb/rmsp_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmsp_partner (
    input  wire logic       sni,
    input  wire logic       tx_clock_pin,
    input  wire logic       rx_clock_pin,
    input  wire logic       rx_valid_out,
    input  wire logic [1:0] rx_data_out,
    output var  logic       ref_clock_in,
    output var  logic       tx_enable_in,
    output var  logic [3:0] tx_data_in,
    output var  logic       tx_error_in
);
    logic bits[$];

    // Reference runs free, phase chosen so its edges never meet clk edges
    initial begin
        ref_clock_in = 1'b0;
        tx_enable_in = 1'b0;
        tx_data_in   = 4'h0;
        tx_error_in  = 1'b0;
        #37;
        forever #100 ref_clock_in = ~ref_clock_in;
    end

    // Symbols change half a period away from the edge the port samples on
    task automatic step();
        if (sni)
            @(negedge tx_clock_pin);
        else
            @(negedge ref_clock_in);
    endtask

    task automatic send(input logic [7:0] b[$], input int err_at, input int hold);
        int w;
        w = sni ? 1 : 2;
        for (int i = 0; i < 8 * b.size(); i += w) begin
            step();
            tx_enable_in = 1'b1;
            tx_data_in = {2'h0, sni ? 1'b0 : b[i/8][(i%8)|1], b[i/8][i%8]};
            tx_error_in = (i == err_at) && !sni;
            repeat (hold - 1) step();
        end
        step();
        tx_enable_in = 1'b0;
        tx_error_in = 1'b0;
        // Released lines must not keep showing the last symbol
        tx_data_in[1:0] = ~tx_data_in[1:0];
    endtask

    always @(posedge ref_clock_in) begin
        if (!sni && rx_valid_out) begin
            bits.push_back(rx_data_out[0]);
            bits.push_back(rx_data_out[1]);
        end
    end

    always @(posedge rx_clock_pin) begin
        if (sni && rx_valid_out)
            bits.push_back(rx_data_out[0]);
    end
endmodule
`default_nettype wire

// ==== tb/test_rmii_sni_switch_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_rmii_sni_switch_port;
    logic                 clk, srst, ce, speed_100, full_duplex;
    rmsp_pkg::rmsp_mode_t mode;
    logic                 ref_clock_in, tx_enable_in, tx_error_in;
    logic [3:0]           tx_data_in;
    logic                 rx_valid_out, collision_out, tx_clock_pin, rx_clock_pin;
    logic [1:0]           rx_data_out;
    rmsp_pkg::rmsp_rxb_t  mac_rx;
    logic                 mac_tx_valid, mac_tx_last, mac_tx_ready, mac_collision;
    logic [7:0]           mac_tx_data;
    logic [7:0]           rxq[$];
    int                   failures, n_checks, n_eof, sof_at;
    logic                 eof_err;

    rmsp_port DUT (.clk(clk), .srst(srst), .ce(ce), .mode(mode), .speed_100(speed_100),
        .full_duplex(full_duplex), .ref_clock_in(ref_clock_in), .tx_enable_in(tx_enable_in),
        .tx_data_in(tx_data_in), .tx_error_in(tx_error_in), .rx_valid_out(rx_valid_out),
        .rx_data_out(rx_data_out), .collision_out(collision_out), .tx_clock_pin(tx_clock_pin),
        .rx_clock_pin(rx_clock_pin), .mac_rx(mac_rx), .mac_tx_valid(mac_tx_valid),
        .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last), .mac_tx_ready(mac_tx_ready),
        .mac_collision(mac_collision));

    rmsp_partner PARTNER (.sni(mode == rmsp_pkg::RMSP_SNI), .tx_clock_pin(tx_clock_pin),
        .rx_clock_pin(rx_clock_pin), .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out),
        .ref_clock_in(ref_clock_in), .tx_enable_in(tx_enable_in), .tx_data_in(tx_data_in),
        .tx_error_in(tx_error_in));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Sampled mid-cycle so each one-cycle pulse is seen once, clear of its launch edge
    always @(negedge clk) begin
        if (mac_rx.valid) begin
            if (mac_rx.sof) sof_at = rxq.size();
            rxq.push_back(mac_rx.data);
        end
        if (mac_rx.eof) begin
            n_eof++;
            eof_err = mac_rx.err;
        end
    end

    task automatic test_done();
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic mac_send(input logic [7:0] b[$]);
        int k;
        foreach (b[i]) begin
            mac_tx_valid = 1'b1;
            mac_tx_data = b[i];
            mac_tx_last = (i == b.size() - 1);
            for (k = 0; k < 500 && mac_tx_ready !== 1'b1; k++) @(negedge clk);
            if (mac_tx_ready !== 1'b1) begin
                failures++;
                test_done();
            end
            @(negedge clk);
        end
        mac_tx_valid = 1'b0;
        mac_tx_last = 1'b0;
    endtask

    // Both directions run at once; collision is judged while both carry data
    task automatic run(input logic [7:0] rb[$], input logic [7:0] tb[$], input int ea, input int h);
        int n0;
        int k;
        n0 = n_eof;
        fork
            PARTNER.send(rb, ea, h);
            mac_send(tb);
            begin
                for (k = 0; k < 300 && !(rx_valid_out && tx_enable_in); k++) @(negedge clk);
                repeat (6) @(negedge clk);
                if (rx_valid_out && tx_enable_in) begin
                    check("mac_col", mac_collision, !full_duplex);
                    check("col_pin", collision_out, !full_duplex && mode);
                end
            end
        join
        for (k = 0; k < 2000 && n_eof == n0; k++) @(negedge clk);
        for (k = 0; k < 2000 && rx_valid_out; k++) @(negedge clk);
        if (n_eof == n0 || rx_valid_out) begin
            failures++;
            test_done();
        end
        repeat (20) @(negedge clk);
    endtask

    task automatic expect_rx(input logic [7:0] b[$], input logic err);
        check("rx_count", rxq.size(), b.size());
        foreach (b[i]) check("rx_byte", rxq[i], b[i]);
        check("rx_sof", sof_at, 0);
        check("rx_err", eof_err, err);
        rxq.delete();
        sof_at = -1;
    endtask

    task automatic expect_tx(input logic [7:0] b[$]);
        logic [7:0] v;
        check("tx_bits", PARTNER.bits.size(), 8 * b.size());
        foreach (b[i]) begin
            for (int j = 0; j < 8; j++) v[j] = PARTNER.bits[8*i+j];
            check("tx_byte", v, b[i]);
        end
        PARTNER.bits.delete();
    endtask

    task automatic clk_check(input int highs);
        int k;
        k = 0;
        repeat (8) begin
            @(negedge clk);
            k += tx_clock_pin;
            check("clk_pair", rx_clock_pin, tx_clock_pin);
        end
        check("clk_high", k, highs);
    endtask

    task automatic t_duplex_rmii();
        clk_check(0);
        run('{8'h55, 8'hD5, 8'hA7}, '{8'h0F, 8'hC3}, -1, 1);
        expect_rx('{8'h55, 8'hD5, 8'hA7}, 1'b0);
        expect_tx('{8'h0F, 8'hC3});
    endtask

    task automatic t_rx_error();
        run('{8'h81, 8'h7E}, '{}, 4, 1);
        expect_rx('{8'h81, 8'h7E}, 1'b1);
    endtask

    task automatic t_rx_slow();
        speed_100 = 1'b0;
        run('{8'h96, 8'h2D}, '{}, -1, 10);
        expect_rx('{8'h96, 8'h2D}, 1'b0);
        speed_100 = 1'b1;
    endtask

    task automatic t_collision();
        full_duplex = 1'b0;
        run('{8'h11, 8'h22, 8'h33, 8'h44}, '{8'hE1, 8'h1E, 8'h5A}, -1, 1);
        expect_rx('{8'h11, 8'h22, 8'h33, 8'h44}, 1'b0);
        PARTNER.bits.delete();
        full_duplex = 1'b1;
    endtask

    task automatic t_sni();
        mode = rmsp_pkg::RMSP_SNI;
        repeat (40) @(negedge clk);
        clk_check(4);
        run('{8'h3C, 8'hB4}, '{8'h6A, 8'h01, 8'hF0}, -1, 1);
        expect_rx('{8'h3C, 8'hB4}, 1'b0);
        expect_tx('{8'h6A, 8'h01, 8'hF0});
        t_collision();
        mode = rmsp_pkg::RMSP_RMII;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        mode = rmsp_pkg::RMSP_RMII;
        speed_100 = 1'b1;
        full_duplex = 1'b1;
        mac_tx_valid = 1'b0;
        mac_tx_data = 8'h00;
        mac_tx_last = 1'b0;
        sof_at = -1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (20) @(negedge clk);
        t_duplex_rmii();
        t_rx_error();
        t_rx_slow();
        t_collision();
        t_sni();
        test_done();
    end
endmodule
`default_nettype wire
